// file: bench/idc_ppi_src.sv
// Source model for the per-processor private interrupt lines
`timescale 1ns/1ps
`default_nettype none
module idc_ppi_src
  import idc_pkg::*;
#(
  parameter int NUM_CPU = 4,  // Processors served
  parameter int LAG     = 2   // Cycles from command to line, at least 1
) (
  input  wire logic                       clk_i,
  input  wire logic [NUM_CPU*NUM_PPI-1:0] lvl_i,
  input  wire logic [NUM_CPU*NUM_PPI-1:0] grp_i,
  output logic      [NUM_CPU*NUM_PPI-1:0] ppi_o,
  output logic      [NUM_CPU*NUM_PPI-1:0] group1_o
);
  // Delay stages; timer logic settles some cycles after a command
  logic [NUM_CPU*NUM_PPI-1:0] pipe [LAG];

  // Shift commanded levels toward the lines
  always_ff @(posedge clk_i) begin
    pipe[0] <= lvl_i;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end

  assign ppi_o    = pipe[LAG-1];
  // Group membership is a static strap, no lag
  assign group1_o = grp_i;
endmodule
`default_nettype wire

// file: bench/irq_distributor_cfg_status_bench.sv
// Self-checking bench for the distributor config and status slice
`timescale 1ns/1ps
`default_nettype none
module irq_distributor_cfg_status_bench
  import idc_pkg::*;
;
  localparam int         NCPU = 4;      // Processors
  localparam int         LAG  = 2;      // Source model delay
  localparam logic [7:0] PC   = 8'hC4;  // Arbitrary value
  localparam logic [3:0] MJ   = 4'h3;   // Arbitrary value
  localparam logic [3:0] MN   = 4'h9;   // Arbitrary value
  localparam logic [11:0] IC  = 12'h2D5; // Arbitrary value

  logic                    clk_i;       // 100 MHz clock
  logic                    rst_i;       // Synchronous reset
  idc_wb_req_t             req;         // Bus request
  idc_wb_rsp_t             rsp;         // Bus answer
  idc_acc_t                acc;         // Sideband world and processor
  logic [NCPU*NUM_PPI-1:0] lvl;         // Commanded input levels
  logic [NCPU*NUM_PPI-1:0] grp;         // Commanded group one mask
  logic [NCPU*NUM_PPI-1:0] ppi;         // Lines into the slice
  logic [NCPU*NUM_PPI-1:0] g1;          // Group lines into the slice
  int                      n_mismatch;  // Failed compares
  int                      comparisons; // All compares
  logic [DAT_W-1:0]        rd;          // Last read data

  idc_dist_slice #(.NUM_IRQ(64), .NUM_CPU(NCPU), .PRODUCT_CODE(PC), .MAJOR_REV(MJ),
    .MINOR_REV(MN), .IMPL_CODE(IC)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .acc_i(acc), .wb_rsp_o(rsp), .ppi_i(ppi), .ppi_group1_i(g1));
  idc_ppi_src #(.NUM_CPU(NCPU), .LAG(LAG)) src (.clk_i(clk_i), .lvl_i(lvl), .grp_i(grp),
    .ppi_o(ppi), .group1_o(g1));

  // Clock generator
  always #5 clk_i = ~clk_i;

  // Final report, also the exit of a hung wait
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled high, then released for a cycle
  task automatic xfer(input logic we, input logic [ADR_W-1:0] a,
                      input logic [SEL_W-1:0] s, input logic [DAT_W-1:0] wd);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    rd = rsp.dat;
    req <= '0;
    if (n >= 50) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, 1'b0, 1'b1);
      give_verdict();
    end
    @(posedge clk_i);
  endtask

  // Read and compare in one step
  task automatic rchk(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
    xfer(1'b0, a, 4'hF, 32'h00000000);
    chk(rd, exp);
  endtask

  // Identification fields and their write protection
  task automatic t_ident();
    logic [DAT_W-1:0] e;
    e = {PC, 4'h0, MJ, MN, IC};
    rchk(OFS_IMPL_ID, e);
    xfer(1'b1, OFS_IMPL_ID, 4'hF, 32'hFFFFFFFF);
    chk(rd, RST_DATA);
    rchk(OFS_IMPL_ID, e);
    $display("test ident done");
  endtask

  // Software and private pairs are fixed; writes leave them alone
  task automatic t_fixed_cfg();
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, OFS_TRIG_CFG + 12'h004, 4'hF, k ? 32'h00000000 : 32'hFFFFFFFF);
      xfer(1'b1, OFS_TRIG_CFG, 4'hF, k ? 32'hFFFFFFFF : 32'h00000000);
      rchk(OFS_TRIG_CFG, 32'hAAAAAAAA);
      rchk(OFS_TRIG_CFG + 12'h004, 32'h55540000);
    end
    $display("test fixed config done");
  endtask

  // Shared pairs: low bit stuck at one, high bit per byte lane
  task automatic t_shared_cfg();
    rchk(OFS_TRIG_CFG + 12'h008, 32'h55555555);
    rchk(OFS_TRIG_CFG + 12'h00C, 32'h55555555);
    xfer(1'b1, OFS_TRIG_CFG + 12'h008, 4'hF, 32'hFFFFFFFF);
    rchk(OFS_TRIG_CFG + 12'h008, 32'hFFFFFFFF);
    rchk(OFS_TRIG_CFG + 12'h00C, 32'h55555555);
    xfer(1'b1, OFS_TRIG_CFG + 12'h008, 4'h2, 32'h00000000);
    rchk(OFS_TRIG_CFG + 12'h008, 32'hFFFF55FF);
    xfer(1'b1, OFS_TRIG_CFG + 12'h00C, 4'hF, 32'h00000000);
    rchk(OFS_TRIG_CFG + 12'h00C, 32'h55555555);
    $display("test shared config done");
  endtask

  // Unmapped and misaligned places read zero and store nothing; past-the-array place reads zero
  task automatic t_unmapped();
    xfer(1'b1, 12'h100, 4'hF, 32'h12345678);
    rchk(12'h100, 32'h00000000);
    xfer(1'b1, OFS_TRIG_CFG + 12'h009, 4'hF, 32'h00000000);
    rchk(OFS_TRIG_CFG + 12'h009, 32'h00000000);
    rchk(OFS_TRIG_CFG + 12'h010, 32'h00000000);
    rchk(OFS_TRIG_CFG + 12'h008, 32'hFFFF55FF);
    $display("test unmapped done");
  endtask

  // One line at a time on processor 0 shows in its own bit
  task automatic t_status_order();
    acc <= '{nonsecure: 1'b0, cpu: 2'h0};
    for (int b = 0; b < NUM_PPI; b++) begin
      lvl <= 28'h0000001 << b;
      repeat (LAG + 3) @(posedge clk_i);
      rchk(OFS_PPI_STAT, 32'h00000001 << (b + PPI_STAT_LSB));
    end
    $display("test status order done");
  endtask

  // Banking per processor, group filtering, live level and write protection
  task automatic t_status_bank();
    logic [6:0] v;
    lvl <= {7'h2A, 7'h55, 7'h0F, 7'h71};
    grp <= {7'h0F, 7'h70, 7'h3C, 7'h55};
    repeat (LAG + 3) @(posedge clk_i);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        acc <= '{nonsecure: c[2], cpu: c[1:0]};
        v = lvl[c[1:0]*7 +: 7] & (c[2] ? grp[c[1:0]*7 +: 7] : 7'h7F);
        rchk(OFS_PPI_STAT, {16'h0000, v, 9'h000});
      end
      xfer(1'b1, OFS_PPI_STAT, 4'hF, 32'hFFFFFFFF);
      chk(rd, RST_DATA);
      lvl <= ~lvl;
      repeat (LAG + 3) @(posedge clk_i);
    end
    $display("test status bank done");
  endtask

  // Main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    req = '0;
    acc = '0;
    lvl = '0;
    grp = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_ident();
    t_fixed_cfg();
    t_shared_cfg();
    t_unmapped();
    t_status_order();
    t_status_bank();
    give_verdict();
  end
endmodule
`default_nettype wire

// file: design/idc_dist_slice.sv
// Distributor slice: identification, trigger configuration and private level status
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Each interrupt owns one two-bit trigger pair
// - Software interrupt pairs fixed, read 0b10
// - Live private peripheral pairs fixed, read 0b01; unused ones (identifiers 16..24) read 0b00
// - Shared pair low bit always reads one
// - Shared pair high bit writable: level or edge
// - Identification: product, implementer, zero reserved nibble
// - Identification carries major and minor revision
// - Status bits 15..9 show private input levels
// - Private input order fixed, maintenance down to fast
// - Status is live level, not pending state
// - Nonsecure reads see only group one inputs
// - Status banked, each processor sees its own
// - Identifiers 0..31 reserved for private use
module idc_dist_slice
  import idc_pkg::*;
#(
  parameter int              NUM_IRQ      = 64,     // Total identifiers, multiple of 32
  parameter int              NUM_CPU      = 4,      // Processors with private inputs
  parameter logic [7:0]      PRODUCT_CODE = 8'h5A,  // Arbitrary value
  parameter logic [3:0]      MAJOR_REV    = 4'h1,   // Arbitrary value
  parameter logic [3:0]      MINOR_REV    = 4'h2,   // Arbitrary value
  parameter logic [11:0]     IMPL_CODE    = 12'h3C1 // Arbitrary value
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire idc_wb_req_t                wb_req_i,
  input  wire idc_acc_t                   acc_i,
  output var idc_wb_rsp_t                 wb_rsp_o,
  input  wire logic [NUM_CPU*NUM_PPI-1:0] ppi_i,
  input  wire logic [NUM_CPU*NUM_PPI-1:0] ppi_group1_i
);

  // Derived sizes
  localparam int NUM_SPI = NUM_IRQ - NUM_PRIVATE;       // Shared lines
  localparam int NUM_CFG = NUM_IRQ / IRQ_PER_WORD;      // Config words
  localparam int PPI_BASE = NUM_PRIVATE - NUM_PPI;      // First live private identifier
  localparam logic [DAT_W-1:0] ID_VALUE = (DAT_W'(PRODUCT_CODE) << ID_PRODUCT_LSB)
                                        | (DAT_W'(MAJOR_REV) << ID_MAJOR_LSB)
                                        | (DAT_W'(MINOR_REV) << ID_MINOR_LSB)
                                        | (DAT_W'(IMPL_CODE) << ID_IMPL_LSB);

  // Bus state
  idc_state_t             state;          // Answer state
  idc_state_t             next_state;
  logic [DAT_W-1:0]       rdata;          // Registered read data
  logic [DAT_W-1:0]       next_rdata;

  // Helper record of the last taken access, read by checks only
  idc_hit_t               last_hit;
  idc_hit_t               next_last_hit;
  logic                   last_stat;
  logic                   next_last_stat;
  idc_acc_t               last_acc;
  idc_acc_t               next_last_acc;

  // Configuration state of shared lines: 1 selects rising edge
  logic [NUM_SPI-1:0]     spi_edge;
  logic [NUM_SPI-1:0]     next_spi_edge;

  // Sampled private inputs
  logic [NUM_CPU*NUM_PPI-1:0] ppi_q;

  // Full trigger view, two bits per identifier
  logic [2*NUM_IRQ-1:0]   cfg_view;

  // Decode of the present request
  logic                   take;           // Request taken this edge
  logic                   hit_id;
  logic                   hit_cfg;
  logic                   hit_stat;
  logic [ADR_W-1:0]       cfg_ofs;
  logic [ADR_W-3:0]       cfg_idx;        // Word index into the config array

  // Taken only from idle, so each request is answered once
  // A master that keeps cyc and stb up past ack is taken again a cycle later
  assign take = wb_req_i.cyc && wb_req_i.stb && (state == ST_IDLE);

  assign hit_id = (wb_req_i.adr == OFS_IMPL_ID);
  assign cfg_ofs = wb_req_i.adr - OFS_TRIG_CFG;
  assign cfg_idx = cfg_ofs[ADR_W-1:2];
  // Misaligned and past-the-array addresses miss every config word
  assign hit_cfg = (wb_req_i.adr >= OFS_TRIG_CFG)
                && (int'(cfg_idx) < NUM_CFG)
                && (cfg_ofs[1:0] == 2'h0);
  assign hit_stat = (wb_req_i.adr == OFS_PPI_STAT);

  // Pair map per identifier
  // ids below 32 never shared
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_pair
      if (g < NUM_SGI) begin : g_sgi
        assign cfg_view[2*g +: 2] = TRIG_SGI_EDGE;
      end else if (g < PPI_BASE) begin : g_gap
        assign cfg_view[2*g +: 2] = TRIG_NONE;
      end else if (g < NUM_PRIVATE) begin : g_ppi
        assign cfg_view[2*g +: 2] = TRIG_LEVEL;
      end else begin : g_spi
        assign cfg_view[2*g +: 2] = {spi_edge[g-NUM_PRIVATE], 1'b1};
      end
    end
  endgenerate

  // Private inputs captured each cycle
  // register before presenting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ppi_q <= '0;
    end else begin
      ppi_q <= ppi_i;
    end
  end

  // Status word for one processor; group mask applies in the nonsecure world
  function automatic logic [DAT_W-1:0] stat_word(input idc_acc_t acc);
    logic [NUM_PPI-1:0] lvl;
    logic [NUM_PPI-1:0] grp;
    lvl = '0;
    grp = '0;
    for (int c = 0; c < NUM_CPU; c++) begin
      if (int'(acc.cpu) == c) begin
        lvl = ppi_q[c*NUM_PPI +: NUM_PPI];
        grp = ppi_group1_i[c*NUM_PPI +: NUM_PPI];
      end
    end
    if (acc.nonsecure) begin
      lvl = lvl & grp;
    end
    // bit 6 maintenance down to bit 0 fast
    return DAT_W'(lvl) << PPI_STAT_LSB;
  endfunction

  // Next bus state, read data and configuration
  always_comb begin
    next_state = state;
    next_rdata = rdata;
    next_spi_edge = spi_edge;
    next_last_hit = last_hit;
    next_last_stat = last_stat;
    next_last_acc = last_acc;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_ACK;
          next_last_acc = acc_i;
          next_last_stat = hit_stat && !wb_req_i.we;
          next_last_hit = HIT_NONE;
          next_rdata = RST_DATA;
          if (!wb_req_i.we) begin
            if (hit_id) begin
              next_rdata = ID_VALUE;
              next_last_hit = HIT_ID;
            end else if (hit_cfg) begin
              next_rdata = cfg_view[32*cfg_idx +: 32];
              next_last_hit = HIT_CFG;
            end else if (hit_stat) begin
              next_rdata = stat_word(acc_i);
            end
          end else if (hit_cfg) begin
            // only shared high bits take writes
            for (int i = 0; i < NUM_SPI; i++) begin
              if (int'(cfg_idx) == ((i + NUM_PRIVATE) * 2 + 1) / 32
                  && wb_req_i.sel[(((i + NUM_PRIVATE) * 2 + 1) % 32) / 8]) begin
                next_spi_edge[i] = wb_req_i.dat[((i + NUM_PRIVATE) * 2 + 1) % 32];
              end
            end
          end
          // Other writes fall through untouched
          // Trade-off: no error answer, so software never sees a bus fault here
        end
      end
      ST_ACK: begin
        // One-cycle answer, then back to idle
        next_state = ST_IDLE;
      end
    endcase
  end

  // Register bus state and configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      rdata <= RST_DATA;
      spi_edge <= {NUM_SPI{SPI_EDGE_RST}};
      last_hit <= HIT_NONE;
      last_stat <= 1'b0;
      last_acc <= '0;
    end else begin
      state <= next_state;
      rdata <= next_rdata;
      spi_edge <= next_spi_edge;
      last_hit <= next_last_hit;
      last_stat <= next_last_stat;
      last_acc <= next_last_acc;
    end
  end

  // Answer: ack for exactly one cycle per taken request
  // One assignment drives the whole answer record
  assign wb_rsp_o = '{ack: (state == ST_ACK), dat: rdata};

  // Checks --------------------------------------------------------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Write to a whole config word; lane handling checked on partial writes by a_lane_kept
  logic                 full_cfg_wr;
  logic [ADR_W-3:0]     wr_idx;         // Word index of the last taken access
  assign full_cfg_wr = take && wb_req_i.we && hit_cfg && (wb_req_i.sel == 4'hF);

  // Index kept for every taken access, so read checks know the word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_idx <= '0;
    end else if (take) begin
      wr_idx <= cfg_idx;
    end
  end

  // Taken request answered next cycle, ack one cycle wide
  sequence s_taken;
    take;
  endsequence
  sequence s_one_ack;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence

  a_ack_one_shot: assert property (s_taken |=> s_one_ack)
    else $error("ack not a single cycle after request");

  // each word read returns its pairs
  a_cfg_word_read: assert property (
    (take && !wb_req_i.we && hit_cfg) |=> (rdata == $past(cfg_view[32*cfg_idx +: 32])))
    else $error("config read data mismatch");

  // software interrupt pairs read as edge
  a_sgi_pairs_fixed: assert property (
    (wb_rsp_o.ack && last_hit == HIT_CFG && wr_idx == '0) |->
      (wb_rsp_o.dat == {IRQ_PER_WORD{TRIG_SGI_EDGE}}))
    else $error("software interrupt pairs not edge");

  // live private pairs read as level, unused ones zero
  a_ppi_pairs_fixed: assert property (
    (wb_rsp_o.ack && last_hit == HIT_CFG && int'(wr_idx) == NUM_SGI / IRQ_PER_WORD) |->
      (wb_rsp_o.dat[31:2*(PPI_BASE-IRQ_PER_WORD)] == {NUM_PPI{TRIG_LEVEL}}
      && wb_rsp_o.dat[2*(PPI_BASE-IRQ_PER_WORD)-1:0] == '0))
    else $error("private pairs not level");

  // shared low bits always read one
  a_spi_low_one: assert property (
    (wb_rsp_o.ack && last_hit == HIT_CFG && int'(wr_idx) >= NUM_PRIVATE / IRQ_PER_WORD) |->
      ((wb_rsp_o.dat & {IRQ_PER_WORD{TRIG_LEVEL}}) == {IRQ_PER_WORD{TRIG_LEVEL}}))
    else $error("shared pair low bit cleared");

  // full-word write visible on the next cycle
  a_spi_write_lands: assert property (
    full_cfg_wr && (int'(cfg_idx) >= 2) |=>
      cfg_view[32*wr_idx +: 32] == ($past(wb_req_i.dat) | 32'h55555555))
    else $error("shared config write lost");

  // identification read returns the fixed value
  a_id_value: assert property (
    (wb_rsp_o.ack && last_hit == HIT_ID) |-> (wb_rsp_o.dat == ID_VALUE
      && wb_rsp_o.dat[23:20] == 4'h0))
    else $error("identification value wrong");

  a_id_revision: assert property (
    (wb_rsp_o.ack && last_hit == HIT_ID) |->
      (wb_rsp_o.dat[19:16] == MAJOR_REV && wb_rsp_o.dat[15:12] == MINOR_REV))
    else $error("revision fields wrong");

  // sampled level follows input after one edge
  // Skipped on the edge right after reset, where the register still holds zero
  a_level_sampled: assert property (!$past(rst_i) |-> ppi_q == $past(ppi_i))
    else $error("private inputs not sampled");

  a_stat_reserved: assert property (
    (wb_rsp_o.ack && last_stat) |->
      (wb_rsp_o.dat[31:16] == 16'h0000 && wb_rsp_o.dat[8:0] == 9'h000))
    else $error("status reserved bits set");

  // nonsecure answer never shows group zero
  a_ns_masked: assert property (
    (take && !wb_req_i.we && hit_stat && acc_i.nonsecure && int'(acc_i.cpu) < NUM_CPU) |=>
      ((rdata[15:9] & ~$past(ppi_group1_i[NUM_PPI*acc_i.cpu +: NUM_PPI])) == 7'h00))
    else $error("group zero status leaked");

  a_bank_own: assert property (
    (take && !wb_req_i.we && hit_stat && !acc_i.nonsecure && int'(acc_i.cpu) < NUM_CPU) |=>
      (rdata[15:9] == $past(ppi_q[NUM_PPI*acc_i.cpu +: NUM_PPI])))
    else $error("status from wrong bank");

  // writes outside shared words change nothing
  a_ro_writes: assert property (
    (take && wb_req_i.we && !(hit_cfg && int'(cfg_idx) >= 2)) |=> $stable(spi_edge))
    else $error("read-only write had effect");

  a_write_zero: assert property (
    (take && wb_req_i.we) |=> (rdata == RST_DATA))
    else $error("write answered with data");

  a_unmapped_zero: assert property (
    (take && !wb_req_i.we && !hit_id && !hit_cfg && !hit_stat) |=> (rdata == RST_DATA))
    else $error("unmapped read not zero");

  // end inputs land at the end bits of the field
  a_stat_order: assert property (
    (take && !wb_req_i.we && hit_stat && !acc_i.nonsecure && int'(acc_i.cpu) < NUM_CPU) |=>
      (rdata[PPI_STAT_LSB] == $past(ppi_q[NUM_PPI*acc_i.cpu])
      && rdata[PPI_STAT_LSB+NUM_PPI-1] == $past(ppi_q[NUM_PPI*acc_i.cpu+NUM_PPI-1])))
    else $error("private input order wrong");

  // a clear byte lane 0 keeps its high bits
  a_lane_kept: assert property (
    (take && wb_req_i.we && hit_cfg && int'(cfg_idx) >= NUM_PRIVATE / IRQ_PER_WORD
      && !wb_req_i.sel[0]) |=>
      (cfg_view[32*wr_idx +: 8] == $past(cfg_view[32*cfg_idx +: 8])))
    else $error("unselected lane written");

endmodule

`default_nettype wire

// file: design/idc_pkg.sv
// Shared constants and carrier types for the distributor config and status slice
package idc_pkg;

  // Bus geometry
  localparam int ADR_W = 12;                      // Byte address width of the slice
  localparam int DAT_W = 32;                      // Wishbone data width
  localparam int SEL_W = 4;                       // Byte lanes
  localparam int CPU_ID_W = 2;                    // Processor number width on the bus side

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_IMPL_ID = 12'h008;   // distributor_implementer_id
  localparam logic [ADR_W-1:0] OFS_TRIG_CFG = 12'hC00;  // interrupt_trigger_config word 0
  localparam logic [ADR_W-1:0] OFS_PPI_STAT = 12'hD00;  // private_input_level_status

  // Identification register field positions
  localparam int ID_PRODUCT_LSB = 24;             // product_code [31:24]
  localparam int ID_MAJOR_LSB = 20 - 4;           // major revision [19:16]
  localparam int ID_MINOR_LSB = 12;               // minor revision [15:12]
  localparam int ID_IMPL_LSB = 0;                 // implementer [11:0]

  // Interrupt identifier map
  localparam int NUM_SGI = 16;                    // Identifiers 0..15
  localparam int NUM_PRIVATE = 32;                // Identifiers 0..31 never shared
  localparam int NUM_PPI = 7;                     // Live private inputs per processor
  localparam int IRQ_PER_WORD = 16;               // Bit-pairs per config word

  // Trigger encodings of one bit-pair
  localparam logic [1:0] TRIG_SGI_EDGE = 2'h2;    // Fixed edge, software interrupts
  localparam logic [1:0] TRIG_LEVEL = 2'h1;       // Active-high level
  localparam logic [1:0] TRIG_NONE = 2'h0;        // Identifier not implemented
  localparam logic SPI_EDGE_RST = 1'h0;           // Shared lines reset to level mode

  // Private status field position
  localparam int PPI_STAT_LSB = 9;                // Levels in [15:9]

  // Reset values
  localparam logic [DAT_W-1:0] RST_DATA = 32'h00000000;

  // Classic Wishbone request as presented by the master
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } idc_wb_req_t;

  // Classic Wishbone answer
  typedef struct packed {
    logic             ack;
    logic [DAT_W-1:0] dat;
  } idc_wb_rsp_t;

  // Side attributes of the access: who is asking and in which world
  typedef struct packed {
    logic                nonsecure;
    logic [CPU_ID_W-1:0] cpu;
  } idc_acc_t;

  // Bus answer state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } idc_state_t;

  // Which register the last taken access hit
  typedef enum logic [2:0] {
    HIT_NONE = 3'b001,
    HIT_ID   = 3'b010,
    HIT_CFG  = 3'b100
  } idc_hit_t;

endpackage
